//--- rtl/bsbse_exec.sv
`timescale 1ns/10ps
// How it works
// - Compare immediate subtracts constant, keeps register, sets Z N V C H, one cycle
// - Register bit skip tests bit, skips next instruction when polarity matches
// - I/O bit skip tests I/O bit, skips on match, flags untouched
// - Generic branch tests flag by index, jumps to pc plus offset plus one
// - Zero, carry and negative branches jump on matching flag, flags untouched
// - Unsigned branches use carry: same-or-higher on zero, lower on one
// - Signed branches use N xor V: ge on zero, lt on one
// - Half-carry branches jump on matching half-carry flag
// - Bit-transfer branches jump on matching bit-transfer flag
// - Overflow branches jump on matching overflow flag
// - Interrupt-state branches jump on matching global interrupt flag
// - I/O force one or zero changes one bit, two cycles, no flags
// - Logical left shift fills bit 0 with zero, sets Z C N V
// - Logical right shift fills bit 7 with zero, sets Z C N V
// - Rotate left moves carry into bit 0 and bit 7 to carry
// - Rotate right moves carry into bit 7 and bit 0 to carry
// - Arithmetic right shift keeps bit 7, sets Z C N V
// - Nibble swap exchanges halves, flags unchanged, one cycle
module bsbse_exec
  import bsbse_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            ref_clk_in,
  input  wire logic            sys_rst_in,
  input  wire logic            issue_in,
  input  bsbse_op_t            op_in,
  input  wire logic [7:0]      rd_data_in,
  input  wire logic [7:0]      imm_in,
  input  wire logic [2:0]      bit_sel_in,
  input  wire logic [6:0]      offset_in,
  input  wire logic [PC_W-1:0] pc_in,
  input  wire logic            next_two_word_in,
  input  wire logic [4:0]      io_addr_in,
  input  wire logic [7:0]      io_rd_data_in,
  input  wire logic            status_flag_register_we_in,
  input  wire logic [7:0]      status_flag_register_wdata_in,
  output logic                 ready_out,
  output logic                 done_out,
  output logic [7:0]           result_out,
  output logic                 result_we_out,
  output logic [PC_W-1:0]      pc_out,
  output logic                 pc_load_out,
  output logic [7:0]           status_flag_register_out,
  output logic [4:0]           io_addr_out,
  output logic [7:0]           io_wdata_out,
  output logic                 io_we_out
);

  bsbse_state_t    state_reg;
  logic [1:0]      remain_reg;
  logic            ready_reg;
  logic            done_reg;
  logic [7:0]      result_reg;
  logic            result_we_reg;
  logic [PC_W-1:0] pc_reg;
  logic            pc_load_reg;
  logic [7:0]      status_flag_register_reg;
  logic [4:0]      io_addr_reg;
  logic [7:0]      io_wdata_reg;
  logic            io_we_reg;
  logic            we_pend_reg;
  logic            pcl_pend_reg;
  logic            io_pend_reg;

  logic            accept;
  logic [7:0]      res_next;
  logic [7:0]      status_flag_register_next;
  logic            res_we;
  logic            flag_we;
  logic            pc_load;
  logic [PC_W-1:0] pc_next;
  logic [1:0]      cyc;
  logic            io_we;
  logic [7:0]      io_wdata_next;
  logic [7:0]      diff;
  logic            shift_c;
  logic            bit_val;
  logic            io_bit;
  logic            skip;
  logic            taken;
  logic [PC_W-1:0] br_target;

  assign accept = issue_in && ready_reg;
  assign bit_val = rd_data_in[bit_sel_in];
  assign io_bit = io_rd_data_in[bit_sel_in];
  assign diff = rd_data_in - imm_in;
  assign br_target = pc_in + {{(PC_W-OFFSET_W){offset_in[6]}}, offset_in}
                   + PC_W'(PC_STEP_NEXT);

  // Branch condition for every branch op
  function automatic logic br_cond(bsbse_op_t op, logic [7:0] s, logic [2:0] sel);
    logic r;
    r = 1'b0;
    case (op)
      OP_BRANCH_FLAG_SET:    r = s[sel];
      OP_BRANCH_FLAG_CLEAR:  r = !s[sel];
      OP_BRANCH_EQUAL:       r = s[FLAG_Z];
      OP_BRANCH_NOT_EQUAL:   r = !s[FLAG_Z];
      OP_BRANCH_CARRY_SET:   r = s[FLAG_C];
      OP_BRANCH_CARRY_CLEAR: r = !s[FLAG_C];
      OP_BRANCH_MINUS:       r = s[FLAG_N];
      OP_BRANCH_PLUS:        r = !s[FLAG_N];
      OP_BRANCH_UNSIGNED_GE: r = !s[FLAG_C];
      OP_BRANCH_UNSIGNED_LT: r = s[FLAG_C];
      OP_BRANCH_SIGNED_GE:   r = !(s[FLAG_N] ^ s[FLAG_V]);
      OP_BRANCH_SIGNED_LT:   r = s[FLAG_N] ^ s[FLAG_V];
      OP_BRANCH_HALF_SET:    r = s[FLAG_H];
      OP_BRANCH_HALF_CLEAR:  r = !s[FLAG_H];
      OP_BRANCH_XFER_SET:    r = s[FLAG_T];
      OP_BRANCH_XFER_CLEAR:  r = !s[FLAG_T];
      OP_BRANCH_OVF_SET:     r = s[FLAG_V];
      OP_BRANCH_OVF_CLEAR:   r = !s[FLAG_V];
      OP_BRANCH_INT_ON:      r = s[FLAG_I];
      OP_BRANCH_INT_OFF:     r = !s[FLAG_I];
      default:               r = 1'b0;
    endcase
    return r;
  endfunction

  // Z N V S after a shift or rotate
  function automatic logic [7:0] shift_flags(logic [7:0] s, logic [7:0] r, logic c);
    logic [7:0] f;
    f = s;
    f[FLAG_C] = c;
    f[FLAG_Z] = (r == BYTE_RST);
    f[FLAG_N] = r[7];
    f[FLAG_V] = r[7] ^ c;
    f[FLAG_S] = c;
    return f;
  endfunction

  // Operation decode
  always_comb begin
    res_next = rd_data_in;
    status_flag_register_next = status_flag_register_reg;
    res_we = 1'b0;
    flag_we = 1'b0;
    pc_load = 1'b0;
    pc_next = pc_in + PC_W'(PC_STEP_NEXT);
    cyc = CYC_ONE;
    io_we = 1'b0;
    io_wdata_next = io_rd_data_in;
    shift_c = 1'b0;
    skip = 1'b0;
    taken = br_cond(op_in, status_flag_register_reg, bit_sel_in);
    unique case (op_in)
      OP_COMPARE_IMMEDIATE: begin
        flag_we = 1'b1;
        status_flag_register_next[FLAG_Z] = (diff == BYTE_RST);
        status_flag_register_next[FLAG_N] = diff[7];
        status_flag_register_next[FLAG_V] = (rd_data_in[7] & !imm_in[7] & !diff[7])
                          | (!rd_data_in[7] & imm_in[7] & diff[7]);
        status_flag_register_next[FLAG_C] = (!rd_data_in[7] & imm_in[7]) | (imm_in[7] & diff[7])
                          | (diff[7] & !rd_data_in[7]);
        status_flag_register_next[FLAG_H] = (!rd_data_in[3] & imm_in[3]) | (imm_in[3] & diff[3])
                          | (diff[3] & !rd_data_in[3]);
        status_flag_register_next[FLAG_S] = status_flag_register_next[FLAG_N] ^ status_flag_register_next[FLAG_V];
      end
      OP_SKIP_REG_BIT_CLEAR: skip = !bit_val;
      OP_SKIP_REG_BIT_SET:   skip = bit_val;
      OP_SKIP_IO_BIT_CLEAR:  skip = !io_bit;
      OP_SKIP_IO_BIT_SET:    skip = io_bit;
      OP_IO_BIT_FORCE_ONE: begin
        io_we = 1'b1;
        io_wdata_next[bit_sel_in] = 1'b1;
        cyc = CYC_TWO;
      end
      OP_IO_BIT_FORCE_ZERO: begin
        io_we = 1'b1;
        io_wdata_next[bit_sel_in] = 1'b0;
        cyc = CYC_TWO;
      end
      OP_SHIFT_LEFT_LOGICAL: begin
        res_next = {rd_data_in[6:0], 1'b0};
        shift_c = rd_data_in[7];
        res_we = 1'b1;
        flag_we = 1'b1;
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        res_next = {1'b0, rd_data_in[7:1]};
        shift_c = rd_data_in[0];
        res_we = 1'b1;
        flag_we = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY: begin
        res_next = {rd_data_in[6:0], status_flag_register_reg[FLAG_C]};
        shift_c = rd_data_in[7];
        res_we = 1'b1;
        flag_we = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res_next = {status_flag_register_reg[FLAG_C], rd_data_in[7:1]};
        shift_c = rd_data_in[0];
        res_we = 1'b1;
        flag_we = 1'b1;
      end
      OP_SHIFT_RIGHT_ARITH: begin
        res_next = {rd_data_in[7], rd_data_in[7:1]};
        shift_c = rd_data_in[0];
        res_we = 1'b1;
        flag_we = 1'b1;
      end
      OP_NIBBLE_SWAP: begin
        res_next = {rd_data_in[3:0], rd_data_in[7:4]};
        res_we = 1'b1;
      end
      default: begin
        if (taken) begin
          pc_load = 1'b1;
          pc_next = br_target;
          cyc = CYC_TWO;
        end
      end
    endcase
    if (skip) begin
      pc_load = 1'b1;
      pc_next = pc_in + PC_W'(next_two_word_in ? PC_STEP_DOUBLE : PC_STEP_SINGLE);
      cyc = next_two_word_in ? CYC_THREE : CYC_TWO;
    end
    if (op_in inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                      OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH}) begin
      status_flag_register_next = shift_flags(status_flag_register_reg, res_next, shift_c);
      status_flag_register_next[FLAG_S] = status_flag_register_next[FLAG_N] ^ status_flag_register_next[FLAG_V];
    end
  end

  // Cycle sequencing
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      remain_reg <= 2'h0;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            if (cyc == CYC_ONE) begin
              done_reg <= 1'b1;
            end else begin
              state_reg <= ST_BUSY;
              ready_reg <= 1'b0;
              remain_reg <= cyc - CYC_ONE;
            end
          end
        end
        ST_BUSY: begin
          if (remain_reg == CYC_ONE) begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
            done_reg <= 1'b1;
          end else begin
            remain_reg <= remain_reg - CYC_ONE;
          end
        end
      endcase
    end
  end

  // Data outputs, captured at issue and held
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      result_reg <= BYTE_RST;
      pc_reg <= '0;
      io_addr_reg <= 5'h00;
      io_wdata_reg <= BYTE_RST;
    end else if (accept) begin
      result_reg <= res_next;
      pc_reg <= pc_next;
      io_addr_reg <= io_addr_in;
      io_wdata_reg <= io_wdata_next;
    end
  end

  // Strobes, raised with done
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      result_we_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      io_we_reg <= 1'b0;
      we_pend_reg <= 1'b0;
      pcl_pend_reg <= 1'b0;
      io_pend_reg <= 1'b0;
    end else begin
      result_we_reg <= 1'b0;
      pc_load_reg <= 1'b0;
      io_we_reg <= 1'b0;
      if (accept && cyc == CYC_ONE) begin
        result_we_reg <= res_we;
        pc_load_reg <= pc_load;
      end else if (accept) begin
        we_pend_reg <= res_we;
        pcl_pend_reg <= pc_load;
        io_pend_reg <= io_we;
      end else if (state_reg == ST_BUSY && remain_reg == CYC_ONE) begin
        result_we_reg <= we_pend_reg;
        pc_load_reg <= pcl_pend_reg;
        io_we_reg <= io_pend_reg;
      end
    end
  end

  // Status flag register; compare never writes its difference back
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_flag_register_reg <= STATUS_FLAG_REGISTER_RST;
    end else if (accept && flag_we) begin
      status_flag_register_reg <= status_flag_register_next;
    end else if (status_flag_register_we_in && !accept) begin
      status_flag_register_reg <= status_flag_register_wdata_in;
    end
  end

  assign ready_out = ready_reg;
  assign done_out = done_reg;
  assign result_out = result_reg;
  assign result_we_out = result_we_reg;
  assign pc_out = pc_reg;
  assign pc_load_out = pc_load_reg;
  assign status_flag_register_out = status_flag_register_reg;
  assign io_addr_out = io_addr_reg;
  assign io_wdata_out = io_wdata_reg;
  assign io_we_out = io_we_reg;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence done_after_two;
    !done_out ##1 done_out && pc_load_out;
  endsequence

  sequence done_after_three;
    !done_out ##1 !done_out ##1 done_out && pc_load_out;
  endsequence

  cmp_no_write_a: assert property (
    accept && op_in == OP_COMPARE_IMMEDIATE |=> done_out && !result_we_out
      && status_flag_register_out[FLAG_Z] == ($past(rd_data_in) == $past(imm_in))
      && status_flag_register_out[FLAG_C] == ($past(rd_data_in) < $past(imm_in)))
    else $error("compare flags wrong");

  skip_reg_a: assert property (
    accept && op_in == OP_SKIP_REG_BIT_CLEAR && !bit_val && !next_two_word_in
      |=> done_after_two ##0 pc_out == $past(pc_in, 2) + PC_W'(PC_STEP_SINGLE))
    else $error("register skip wrong");

  skip_io_a: assert property (
    accept && op_in == OP_SKIP_IO_BIT_SET && io_bit && next_two_word_in
      |=> done_after_three ##0 status_flag_register_out == $past(status_flag_register_out, 3))
    else $error("io skip wrong");

  skip_none_a: assert property (
    accept && op_in == OP_SKIP_REG_BIT_SET && !bit_val
      |=> done_out && !pc_load_out)
    else $error("untaken skip wrong");

  br_flag_a: assert property (
    accept && op_in == OP_BRANCH_FLAG_SET && status_flag_register_out[bit_sel_in]
      |=> done_after_two ##0 pc_out == $past(br_target, 2))
    else $error("flag branch wrong");

  br_eq_not_a: assert property (
    accept && op_in == OP_BRANCH_EQUAL && !status_flag_register_out[FLAG_Z]
      |=> done_out && !pc_load_out && $stable(status_flag_register_out))
    else $error("equal branch wrong");

  br_unsigned_a: assert property (
    accept && op_in == OP_BRANCH_UNSIGNED_LT && status_flag_register_out[FLAG_C] |=> done_after_two)
    else $error("unsigned branch wrong");

  br_signed_a: assert property (
    accept && op_in == OP_BRANCH_SIGNED_GE && (status_flag_register_out[FLAG_N] == status_flag_register_out[FLAG_V])
      |=> done_after_two)
    else $error("signed branch wrong");

  io_force_a: assert property (
    accept && op_in == OP_IO_BIT_FORCE_ONE
      |=> !io_we_out ##1 io_we_out && io_wdata_out[$past(bit_sel_in, 2)]
      && io_addr_out == $past(io_addr_in, 2))
    else $error("io force wrong");

  shl_a: assert property (
    accept && op_in == OP_SHIFT_LEFT_LOGICAL |=> result_we_out
      && result_out == {$past(rd_data_in[6:0]), 1'b0}
      && status_flag_register_out[FLAG_C] == $past(rd_data_in[7]))
    else $error("left shift wrong");

  swap_a: assert property (
    accept && op_in == OP_NIBBLE_SWAP |=> result_out == {$past(rd_data_in[3:0]),
      $past(rd_data_in[7:4])} && status_flag_register_out == $past(status_flag_register_out))
    else $error("swap wrong");

endmodule

//--- rtl/bsbse_pkg.sv
package bsbse_pkg;

  // Status flag positions in the status_flag_register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Reset values
  localparam logic [7:0] STATUS_FLAG_REGISTER_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Program counter steps in words
  localparam int PC_STEP_NEXT   = 1;
  localparam int PC_STEP_SINGLE = 2;
  localparam int PC_STEP_DOUBLE = 3;
  localparam int OFFSET_W       = 7;

  typedef enum logic [5:0] {
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_UNSIGNED_LT,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALF_SET,
    OP_BRANCH_HALF_CLEAR,
    OP_BRANCH_XFER_SET,
    OP_BRANCH_XFER_CLEAR,
    OP_BRANCH_OVF_SET,
    OP_BRANCH_OVF_CLEAR,
    OP_BRANCH_INT_ON,
    OP_BRANCH_INT_OFF,
    OP_IO_BIT_FORCE_ONE,
    OP_IO_BIT_FORCE_ZERO,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH,
    OP_NIBBLE_SWAP
  } bsbse_op_t;

  typedef enum {
    ST_IDLE,
    ST_BUSY
  } bsbse_state_t;

endpackage

//--- verification/bsbse_io_model.sv
`timescale 1ns/10ps
module bsbse_io_model (
  input  wire logic       ref_clk_in,
  input  wire logic [4:0] rd_addr_in,
  output logic [7:0]      rd_data_out,
  input  wire logic       wr_en_in,
  input  wire logic [4:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in
);
  logic [7:0] mem [32];

  // Fixed start pattern so every address differs
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end

  assign rd_data_out = mem[rd_addr_in];

  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import bsbse_pkg::*;
;
  typedef struct packed {
    logic [1:0]  cyc;
    logic        ld;
    logic [15:0] pc;
    logic        rwe;
    logic [7:0]  res;
    logic [7:0]  sr;
    logic        iwe;
    logic [7:0]  iod;
  } bsbse_exp_t;

  logic        clk;
  logic        rst;
  logic        issue;
  bsbse_op_t   op_q;
  logic [7:0]  rd_q;
  logic [7:0]  imm_q;
  logic [2:0]  bit_q;
  logic [6:0]  off_q;
  logic [15:0] pc_q;
  logic        two_q;
  logic [4:0]  ia_q;
  logic [7:0]  io_rd;
  logic        status_flag_register_we;
  logic [7:0]  status_flag_register_wdata;
  logic        ready_out;
  logic        done_out;
  logic [7:0]  result_out;
  logic        result_we_out;
  logic [15:0] pc_out;
  logic        pc_load_out;
  logic [7:0]  status_flag_register_out;
  logic [4:0]  io_addr_out;
  logic [7:0]  io_wdata_out;
  logic        io_we_out;
  int          failures;
  int          check_count;

  bsbse_exec #(.PC_W(16)) u_dut (
    .ref_clk_in(clk), .sys_rst_in(rst), .issue_in(issue), .op_in(op_q), .rd_data_in(rd_q),
    .imm_in(imm_q), .bit_sel_in(bit_q), .offset_in(off_q), .pc_in(pc_q), .next_two_word_in(two_q),
    .io_addr_in(ia_q), .io_rd_data_in(io_rd), .status_flag_register_we_in(status_flag_register_we), .status_flag_register_wdata_in(status_flag_register_wdata),
    .ready_out(ready_out), .done_out(done_out), .result_out(result_out), .result_we_out(result_we_out),
    .pc_out(pc_out), .pc_load_out(pc_load_out), .status_flag_register_out(status_flag_register_out), .io_addr_out(io_addr_out),
    .io_wdata_out(io_wdata_out), .io_we_out(io_we_out)
  );

  bsbse_io_model u_io (
    .ref_clk_in(clk), .rd_addr_in(ia_q), .rd_data_out(io_rd), .wr_en_in(io_we_out),
    .wr_addr_in(io_addr_out), .wr_data_in(io_wdata_out)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_val(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic bsbse_exp_t expect_op(bsbse_op_t op, logic [7:0] rd, logic [7:0] imm, logic [7:0] io,
                                           logic [7:0] s, logic [2:0] b, logic [6:0] k, logic [15:0] pc,
                                           logic two);
    bsbse_exp_t e;
    logic [7:0] r;
    logic       tk;
    logic       br;
    logic       sh;
    e = '0;
    e.sr = s;
    e.cyc = CYC_ONE;
    r = 8'h00;
    tk = 1'b0;
    br = 1'b1;
    sh = 1'b0;
    case (op)
      OP_COMPARE_IMMEDIATE: begin
        br = 1'b0;
        r = rd - imm;
        e.sr[FLAG_C] = imm > rd;
        e.sr[FLAG_Z] = r == 8'h00;
        e.sr[FLAG_N] = r[7];
        e.sr[FLAG_V] = (rd[7] & ~imm[7] & ~r[7]) | (~rd[7] & imm[7] & r[7]);
        e.sr[FLAG_H] = (~rd[3] & imm[3]) | (imm[3] & r[3]) | (r[3] & ~rd[3]);
        e.sr[FLAG_S] = e.sr[FLAG_N] ^ e.sr[FLAG_V];
      end
      OP_SKIP_REG_BIT_CLEAR: tk = !rd[b];
      OP_SKIP_REG_BIT_SET: tk = rd[b];
      OP_SKIP_IO_BIT_CLEAR: tk = !io[b];
      OP_SKIP_IO_BIT_SET: tk = io[b];
      OP_BRANCH_FLAG_SET: tk = s[b];
      OP_BRANCH_FLAG_CLEAR: tk = !s[b];
      OP_BRANCH_EQUAL: tk = s[FLAG_Z];
      OP_BRANCH_NOT_EQUAL: tk = !s[FLAG_Z];
      OP_BRANCH_CARRY_SET, OP_BRANCH_UNSIGNED_LT: tk = s[FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE: tk = !s[FLAG_C];
      OP_BRANCH_MINUS: tk = s[FLAG_N];
      OP_BRANCH_PLUS: tk = !s[FLAG_N];
      OP_BRANCH_SIGNED_GE: tk = !(s[FLAG_N] ^ s[FLAG_V]);
      OP_BRANCH_SIGNED_LT: tk = s[FLAG_N] ^ s[FLAG_V];
      OP_BRANCH_HALF_SET: tk = s[FLAG_H];
      OP_BRANCH_HALF_CLEAR: tk = !s[FLAG_H];
      OP_BRANCH_XFER_SET: tk = s[FLAG_T];
      OP_BRANCH_XFER_CLEAR: tk = !s[FLAG_T];
      OP_BRANCH_OVF_SET: tk = s[FLAG_V];
      OP_BRANCH_OVF_CLEAR: tk = !s[FLAG_V];
      OP_BRANCH_INT_ON: tk = s[FLAG_I];
      OP_BRANCH_INT_OFF: tk = !s[FLAG_I];
      OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: begin
        br = 1'b0;
        e.cyc = CYC_TWO;
        e.iwe = 1'b1;
        e.iod = (op == OP_IO_BIT_FORCE_ONE) ? (io | (8'h01 << b)) : (io & ~(8'h01 << b));
      end
      OP_NIBBLE_SWAP: begin
        br = 1'b0;
        e.rwe = 1'b1;
        e.res = {rd[3:0], rd[7:4]};
      end
      default: begin
        br = 1'b0;
        sh = 1'b1;
        case (op)
          OP_SHIFT_LEFT_LOGICAL: r = {rd[6:0], 1'b0};
          OP_SHIFT_RIGHT_LOGICAL: r = {1'b0, rd[7:1]};
          OP_ROTATE_LEFT_CARRY: r = {rd[6:0], s[FLAG_C]};
          OP_ROTATE_RIGHT_CARRY: r = {s[FLAG_C], rd[7:1]};
          default: r = {rd[7], rd[7:1]};
        endcase
        e.sr[FLAG_C] = (op == OP_SHIFT_LEFT_LOGICAL || op == OP_ROTATE_LEFT_CARRY) ? rd[7] : rd[0];
      end
    endcase
    if (sh) begin
      e.rwe = 1'b1;
      e.res = r;
      e.sr[FLAG_Z] = r == 8'h00;
      e.sr[FLAG_N] = r[7];
      e.sr[FLAG_V] = r[7] ^ e.sr[FLAG_C];
      e.sr[FLAG_S] = e.sr[FLAG_N] ^ e.sr[FLAG_V];
    end
    if (br && tk) begin
      e.ld = 1'b1;
      if (op inside {[OP_SKIP_REG_BIT_CLEAR:OP_SKIP_IO_BIT_SET]}) begin
        e.cyc = two ? CYC_THREE : CYC_TWO;
        e.pc = pc + (two ? 16'h0003 : 16'h0002);
      end else begin
        e.cyc = CYC_TWO;
        e.pc = pc + {{9{k[6]}}, k} + 16'h0001;
      end
    end
    return e;
  endfunction

  task automatic run_op(bsbse_op_t op, logic [7:0] rd, logic [7:0] imm, logic [7:0] sr, logic [2:0] b,
                        logic [6:0] k, logic [15:0] pc, logic two, logic [4:0] ia);
    bsbse_exp_t e;
    int         n;
    @(posedge clk);
    status_flag_register_we <= 1'b1;
    status_flag_register_wdata <= sr;
    @(posedge clk);
    status_flag_register_we <= 1'b0;
    op_q <= op;
    {rd_q, imm_q, bit_q, off_q, pc_q, two_q, ia_q} <= {rd, imm, b, k, pc, two, ia};
    issue <= 1'b1;
    #1;
    e = expect_op(op, rd, imm, io_rd, sr, b, k, pc, two);
    @(posedge clk);
    issue <= 1'b0;
    #1;
    n = 1;
    while (done_out !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_val(16'(n), 16'(e.cyc));
    check_val(16'(ready_out), 16'h0001);
    check_val(16'(pc_load_out), 16'(e.ld));
    if (e.ld) check_val(pc_out, e.pc);
    check_val(16'(result_we_out), 16'(e.rwe));
    if (e.rwe) check_val(16'(result_out), 16'(e.res));
    check_val(16'(status_flag_register_out), 16'(e.sr));
    check_val(16'(io_we_out), 16'(e.iwe));
    if (e.iwe) check_val({3'h0, io_addr_out, io_wdata_out}, {3'h0, ia, e.iod});
  endtask

  initial begin
    #160000;
    failures++;
    complete_run();
  end

  initial begin
    logic [7:0] rd;
    logic [7:0] imm;
    logic [7:0] sr;
    logic [6:0] k;
    {issue, rd_q, imm_q, bit_q, off_q, pc_q, two_q, ia_q, status_flag_register_we, status_flag_register_wdata} = '0;
    op_q = OP_COMPARE_IMMEDIATE;
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    void'($urandom(32'h3ab9_14d2));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int rep = 0; rep < 8; rep++) begin
      for (int i = 0; i <= int'(OP_NIBBLE_SWAP); i++) begin
        rd = 8'($urandom);
        imm = 8'($urandom);
        sr = 8'($urandom);
        k = 7'($urandom);
        // Boundary values first: sign bit, borrow, extreme offsets, all flags
        if (rep == 0) {rd, imm, sr, k} = {8'h80, 8'h01, 8'hff, 7'h40};
        if (rep == 1) {rd, imm, sr, k} = {8'h00, 8'h00, 8'h00, 7'h3f};
        if (rep == 2) {rd, imm, sr, k} = {8'h01, 8'h80, 8'h55, 7'h00};
        run_op(bsbse_op_t'(i), rd, imm, sr, 3'($urandom), k, 16'($urandom), rep[0], 5'($urandom));
      end
    end
    complete_run();
  end
endmodule
